// >>> hdl/rtd_alarm_trip_pkg.sv
// Package: constants and carriers for the temperature alarm and trip aggregator
// Function
// - Up to four groups feed any-group combiner
// - Any-group alarm, timeout, trip are ORs
// - Group uses hottest enabled member temperature
// - Any enabled member timeout sets group timeout
// - Alarm delayed above threshold, trip immediate
// - Voting trip when tripping count reaches setting
// - Collective timeout ORs sensor and group timeouts
// - Source select: default trips or voting trips
// - Block input suppresses every trip output
// - Release below 0.99 times threshold
// - Voting needs selection, channel and function enable
package rtd_alarm_trip_pkg;
    // ==========================================
    // Sizes
    localparam int NUM_CH     = 12;
    localparam int NUM_GRP    = 4;
    localparam int NUM_VOTE   = 2;
    localparam int TEMP_W     = 12;
    localparam int DLY_W      = 16;
    localparam int CNT_W      = 4;
    // Release ratio 0.99 as 99/100
    localparam int HYS_NUM    = 99;
    localparam int HYS_DEN    = 100;
    // Fixed channel to group map: 2 bits per channel
    localparam logic [2*NUM_CH-1:0] GRP_MAP = 24'hfa5000;
    localparam logic [NUM_CH-1:0]   ZERO_CH = 12'h000;

    typedef logic [TEMP_W-1:0] temp_t;

    typedef struct packed {
        logic alarm;
        logic timeout;
        logic trip;
    } flags_s;

    typedef struct packed {
        logic             enable;
        logic [NUM_CH-1:0] select;
        logic [CNT_W-1:0] required;
    } vote_cfg_s;
endpackage

// >>> hdl/rtd_alarm_trip_aggregator.sv
// Module: temperature alarm, timeout and trip aggregation with voting
`timescale 1ns/1ns
`default_nettype none
module rtd_alarm_trip_aggregator (
    // Clock and reset
    input  wire logic                                        sys_clk,
    input  wire logic                                        nrst,
    // Channel readings
    input  wire rtd_alarm_trip_pkg::temp_t [rtd_alarm_trip_pkg::NUM_CH-1:0] ch_temp,
    input  wire logic [rtd_alarm_trip_pkg::NUM_CH-1:0]       ch_timeout,
    // Configuration
    input  wire logic                                        func_enable,
    input  wire logic [rtd_alarm_trip_pkg::NUM_CH-1:0]       ch_enable,
    input  wire rtd_alarm_trip_pkg::temp_t [rtd_alarm_trip_pkg::NUM_GRP-1:0] grp_alarm_thr,
    input  wire rtd_alarm_trip_pkg::temp_t [rtd_alarm_trip_pkg::NUM_GRP-1:0] grp_trip_thr,
    input  wire rtd_alarm_trip_pkg::temp_t [rtd_alarm_trip_pkg::NUM_CH-1:0]  ch_trip_thr,
    input  wire logic [rtd_alarm_trip_pkg::DLY_W-1:0]        alarm_delay,
    input  wire rtd_alarm_trip_pkg::vote_cfg_s [rtd_alarm_trip_pkg::NUM_VOTE-1:0] vote_cfg,
    input  wire logic                                        trip_source_select,
    input  wire logic                                        block_trip,
    // Results
    output rtd_alarm_trip_pkg::flags_s [rtd_alarm_trip_pkg::NUM_GRP-1:0] grp_flags,
    output rtd_alarm_trip_pkg::flags_s                       any_group_combiner,
    output logic                                             any_group_timeout_alarm,
    output logic                                             winding_group_timeout_alarm,
    output logic                                             auxiliary_group_timeout_alarm,
    output logic                                             voting_trip_first,
    output logic                                             voting_trip_second,
    output logic                                             collective_timeout_alarm,
    output logic                                             final_trip
);
    localparam int G = rtd_alarm_trip_pkg::NUM_GRP;
    localparam int C = rtd_alarm_trip_pkg::NUM_CH;
    localparam int V = rtd_alarm_trip_pkg::NUM_VOTE;
    localparam int HN = rtd_alarm_trip_pkg::HYS_NUM;
    localparam int HD = rtd_alarm_trip_pkg::HYS_DEN;

    // Hysteresis compare: set above thr, hold until below 0.99*thr
    function automatic logic hys_cmp(input logic [11:0] t, input logic [11:0] thr,
                                     input logic prev);
        logic [18:0] lhs;
        logic [18:0] rhs;
        lhs = 19'(t) * 19'(rtd_alarm_trip_pkg::HYS_DEN);
        rhs = 19'(thr) * 19'(rtd_alarm_trip_pkg::HYS_NUM);
        hys_cmp = prev ? (lhs >= rhs) : (t > thr);
    endfunction

    function automatic logic [1:0] grp_of(input int ch);
        grp_of = rtd_alarm_trip_pkg::GRP_MAP[2*ch +: 2];
    endfunction

    // ==========================================
    // Group hottest reading and timeout
    rtd_alarm_trip_pkg::temp_t [G-1:0] grp_max;
    logic [G-1:0]                      grp_to;
    always_comb begin
        for (int g = 0; g < G; g++) begin
            grp_max[g] = '0;
            grp_to[g]  = 1'b0;
        end
        for (int c = 0; c < C; c++) begin
            if (ch_enable[c] && ch_temp[c] > grp_max[grp_of(c)]) begin
                grp_max[grp_of(c)] = ch_temp[c];
            end
            if (ch_enable[c] && ch_timeout[c]) begin
                grp_to[grp_of(c)] = 1'b1;
            end
        end
    end

    // ==========================================
    // Comparators, alarm delay and voting
    logic [G-1:0]                            g_alm_cmp_q, g_alm_cmp_d;
    logic [G-1:0]                            g_trp_cmp_q, g_trp_cmp_d;
    logic [C-1:0]                            c_trp_q, c_trp_d;
    logic [G-1:0][rtd_alarm_trip_pkg::DLY_W-1:0] dly_q, dly_d;
    rtd_alarm_trip_pkg::flags_s [G-1:0]      gf_d;
    rtd_alarm_trip_pkg::flags_s              any_d;
    logic [V-1:0]                            vote_d;
    logic [3:0]                              cnt;
    logic                                    to_any_d, coll_d, fin_d;

    always_comb begin
        cnt = '0;
        for (int g = 0; g < G; g++) begin
            g_alm_cmp_d[g] = func_enable & hys_cmp(grp_max[g], grp_alarm_thr[g], g_alm_cmp_q[g]);
            g_trp_cmp_d[g] = func_enable & hys_cmp(grp_max[g], grp_trip_thr[g], g_trp_cmp_q[g]);
            if (!g_alm_cmp_d[g]) begin
                dly_d[g] = '0;
            end else if (dly_q[g] < alarm_delay) begin
                dly_d[g] = dly_q[g] + 1'b1;
            end else begin
                dly_d[g] = dly_q[g];
            end
            gf_d[g].alarm   = g_alm_cmp_d[g] && (dly_q[g] >= alarm_delay);
            gf_d[g].trip    = g_trp_cmp_d[g] && !block_trip;
            gf_d[g].timeout = func_enable && grp_to[g];
        end
        for (int c = 0; c < C; c++) begin
            c_trp_d[c] = func_enable & ch_enable[c] &
                         hys_cmp(ch_temp[c], ch_trip_thr[c], c_trp_q[c]);
        end
        for (int v = 0; v < V; v++) begin
            cnt = '0;
            for (int c = 0; c < C; c++) begin
                cnt = cnt + 4'(vote_cfg[v].select[c] & ch_enable[c] & func_enable
                                & c_trp_d[c]);
            end
            vote_d[v] = vote_cfg[v].enable && vote_cfg[v].required != '0 &&
                        cnt >= vote_cfg[v].required && !block_trip;
        end
        any_d.alarm   = |{gf_d[3].alarm, gf_d[2].alarm, gf_d[1].alarm, gf_d[0].alarm};
        any_d.timeout = |{gf_d[3].timeout, gf_d[2].timeout,
                          gf_d[1].timeout, gf_d[0].timeout};
        any_d.trip    = |{gf_d[3].trip, gf_d[2].trip, gf_d[1].trip, gf_d[0].trip};
        to_any_d      = any_d.timeout;
        coll_d        = (func_enable && |(ch_timeout & ch_enable)) || any_d.timeout;
        fin_d         = !block_trip && (trip_source_select ? |vote_d
                        : (any_d.trip || |c_trp_d));
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            g_alm_cmp_q                   <= '0;
            g_trp_cmp_q                   <= '0;
            c_trp_q                       <= '0;
            dly_q                         <= '0;
            grp_flags                     <= '0;
            any_group_combiner            <= '0;
            any_group_timeout_alarm       <= 1'b0;
            winding_group_timeout_alarm   <= 1'b0;
            auxiliary_group_timeout_alarm <= 1'b0;
            voting_trip_first             <= 1'b0;
            voting_trip_second            <= 1'b0;
            collective_timeout_alarm      <= 1'b0;
            final_trip                    <= 1'b0;
        end else begin
            g_alm_cmp_q                   <= g_alm_cmp_d;
            g_trp_cmp_q                   <= g_trp_cmp_d;
            c_trp_q                       <= c_trp_d;
            dly_q                         <= dly_d;
            grp_flags                     <= gf_d;
            any_group_combiner            <= any_d;
            any_group_timeout_alarm       <= to_any_d;
            winding_group_timeout_alarm   <= gf_d[0].timeout;
            auxiliary_group_timeout_alarm <= gf_d[3].timeout;
            voting_trip_first             <= vote_d[0];
            voting_trip_second            <= vote_d[1];
            collective_timeout_alarm      <= coll_d;
            final_trip                    <= fin_d;
        end
    end

    // ==========================================
    // Assertions
    AST_BLOCK_FINAL: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(block_trip) |-> !final_trip) else $error("final trip while blocked");
    AST_BLOCK_VOTE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(block_trip) |-> !voting_trip_first && !voting_trip_second)
        else $error("vote trip while blocked");
    AST_ANY_TRIP: assert property (@(posedge sys_clk) disable iff (!nrst)
        any_group_combiner.trip == (|{grp_flags[0].trip, grp_flags[1].trip,
                                     grp_flags[2].trip, grp_flags[3].trip}))
        else $error("any trip not OR of groups");
    AST_ANY_ALARM: assert property (@(posedge sys_clk) disable iff (!nrst)
        any_group_combiner.alarm == (|{grp_flags[0].alarm, grp_flags[1].alarm,
                                      grp_flags[2].alarm, grp_flags[3].alarm}))
        else $error("any alarm not OR of groups");
    AST_COLL_TO: assert property (@(posedge sys_clk) disable iff (!nrst)
        any_group_timeout_alarm |-> collective_timeout_alarm)
        else $error("collective timeout missing");
    AST_SEL_VOTE: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(trip_source_select) && !voting_trip_first && !voting_trip_second
        |-> !final_trip) else $error("final trip without vote");
    AST_ALARM_DLY: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(grp_flags[0].alarm) && $past(alarm_delay) != '0 |-> $past(g_alm_cmp_q[0]))
        else $error("alarm not delayed");
    AST_RESET: assert property (@(posedge sys_clk)
        $rose(nrst) |-> !final_trip && !collective_timeout_alarm && !any_group_combiner.trip)
        else $error("outputs active after reset");
    AST_TO_GRP: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(func_enable) && $past(ch_enable[10]) && $past(ch_timeout[10])
        |-> grp_flags[3].timeout) else $error("group timeout missed");
    AST_HOTTEST: assert property (@(posedge sys_clk) disable iff (!nrst)
        1'b1 |-> grp_max[0] >= (ch_enable[0] ? ch_temp[0] : 12'h000))
        else $error("group max below member");
    AST_VOTE_SEL: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(func_enable) && $past(trip_source_select) |-> !final_trip)
        else $error("vote with function off");
    AST_HYS: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(g_trp_cmp_q[0]) && $past(func_enable) &&
        $past(grp_max[0]) * HD >= $past(grp_trip_thr[0]) * HN |-> g_trp_cmp_q[0])
        else $error("trip released above hysteresis band");
    AST_HYS_REL: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(g_trp_cmp_q[0]) &&
        $past(grp_max[0]) * HD < $past(grp_trip_thr[0]) * HN |-> !g_trp_cmp_q[0])
        else $error("trip held below hysteresis band");
    AST_TRIP_NOW: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(func_enable) && !$past(block_trip) &&
        $past(grp_max[0]) > $past(grp_trip_thr[0]) |-> grp_flags[0].trip)
        else $error("group trip not immediate");
    AST_FINAL_DEF: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(trip_source_select) && any_group_combiner.trip |-> final_trip)
        else $error("default trip not passed to final trip");
    AST_ANY_TO: assert property (@(posedge sys_clk) disable iff (!nrst)
        any_group_timeout_alarm == (|{grp_flags[0].timeout, grp_flags[1].timeout,
                                     grp_flags[2].timeout, grp_flags[3].timeout}))
        else $error("any timeout not OR of groups");
    AST_COLL_CH: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) && $past(func_enable) && $past(ch_enable[10]) && $past(ch_timeout[10])
        |-> collective_timeout_alarm) else $error("channel timeout not collected");
    AST_V_REQ: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(vote_cfg[0].enable) |-> !voting_trip_first)
        else $error("vote trip while disabled");

    COV_FINAL: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(final_trip));
    COV_VOTE: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(voting_trip_second));
    COV_ALARM: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(any_group_combiner.alarm));
    COV_TIMEOUT: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(collective_timeout_alarm));
endmodule
`default_nettype wire

// >>> dv/temp_source_model.sv
// Remote temperature acquisition model holding per-channel readings
`timescale 1ns/1ns
`default_nettype none
module temp_source_model (
    // Clock and reset
    input  wire logic                                                  sys_clk,
    input  wire logic                                                  nrst,
    // Update request
    input  wire logic                                                  upd,
    input  wire logic [3:0]                                            upd_idx,
    input  wire rtd_alarm_trip_pkg::temp_t                             upd_temp,
    input  wire logic                                                  upd_tout,
    // Readings
    output rtd_alarm_trip_pkg::temp_t [rtd_alarm_trip_pkg::NUM_CH-1:0] ch_temp,
    output logic [rtd_alarm_trip_pkg::NUM_CH-1:0]                      ch_timeout
);
    // One channel refreshed per request, others keep their last reading
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ch_temp    <= {rtd_alarm_trip_pkg::NUM_CH{12'h064}};
            ch_timeout <= '0;
        end else if (upd) begin
            ch_temp[upd_idx]    <= upd_temp;
            ch_timeout[upd_idx] <= upd_tout;
        end
    end
endmodule
`default_nettype wire

// >>> dv/rtd_alarm_trip_aggregator_bench.sv
// Self-checking bench for the temperature alarm and trip aggregator
`timescale 1ns/1ns
`default_nettype none
module rtd_alarm_trip_aggregator_bench;
    logic sys_clk = 1'b0, nrst = 1'b0, func_enable = 1'b1, tsel = 1'b0, blk = 1'b0;
    logic upd = 1'b0, upd_tout = 1'b0;
    logic [3:0] upd_idx = 4'h0;
    logic [11:0] ch_enable = 12'hfff, ch_timeout;
    logic [15:0] alarm_delay = 16'h0005;
    rtd_alarm_trip_pkg::temp_t upd_temp = 12'h064;
    rtd_alarm_trip_pkg::temp_t [11:0] ch_temp, ch_thr = {12{12'hfff}};
    rtd_alarm_trip_pkg::temp_t [3:0] g_alm = {4{12'h200}}, g_trp = {4{12'h3e8}};
    rtd_alarm_trip_pkg::vote_cfg_s [1:0] vote_cfg = '0;
    rtd_alarm_trip_pkg::flags_s [3:0] grp_flags;
    rtd_alarm_trip_pkg::flags_s any_g;
    logic any_to, wd_to, aux_to, vt1, vt2, coll_to, final_trip;
    int n_fail = 0, check_count = 0;

    always #20 sys_clk = ~sys_clk;

    temp_source_model src (.sys_clk(sys_clk), .nrst(nrst), .upd(upd), .upd_idx(upd_idx),
        .upd_temp(upd_temp), .upd_tout(upd_tout), .ch_temp(ch_temp), .ch_timeout(ch_timeout));

    rtd_alarm_trip_aggregator dut (.sys_clk(sys_clk), .nrst(nrst), .ch_temp(ch_temp),
        .ch_timeout(ch_timeout), .func_enable(func_enable), .ch_enable(ch_enable),
        .grp_alarm_thr(g_alm), .grp_trip_thr(g_trp), .ch_trip_thr(ch_thr),
        .alarm_delay(alarm_delay), .vote_cfg(vote_cfg), .trip_source_select(tsel),
        .block_trip(blk), .grp_flags(grp_flags), .any_group_combiner(any_g),
        .any_group_timeout_alarm(any_to), .winding_group_timeout_alarm(wd_to),
        .auxiliary_group_timeout_alarm(aux_to), .voting_trip_first(vt1),
        .voting_trip_second(vt2), .collective_timeout_alarm(coll_to), .final_trip(final_trip));

    // ==========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic set_ch(input logic [3:0] i, input logic [11:0] t, input logic to);
        upd = 1'b1; upd_idx = i; upd_temp = t; upd_tout = to;
        cyc(1);
        upd = 1'b0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic s_trip_hyst;
        set_ch(4'h3, 12'h3e9, 1'b0);
        cyc(1);
        chk("grp0 trip", 1'b1, grp_flags[0].trip);
        chk("grp1 trip", 1'b0, grp_flags[1].trip);
        chk("any trip", 1'b1, any_g.trip);
        chk("final trip", 1'b1, final_trip);
        set_ch(4'h3, 12'h3de, 1'b0);
        cyc(1);
        chk("trip held", 1'b1, grp_flags[0].trip);
        set_ch(4'h3, 12'h3dd, 1'b0);
        cyc(1);
        chk("trip released", 1'b0, grp_flags[0].trip);
        set_ch(4'h3, 12'h064, 1'b0);
        cyc(1);
        chk("grp0 alarm released", 1'b0, grp_flags[0].alarm);
    endtask
    task automatic s_block;
        blk = 1'b1;
        set_ch(4'h8, 12'h3e9, 1'b0);
        cyc(1);
        chk("blocked grp2 trip", 1'b0, grp_flags[2].trip);
        chk("blocked final", 1'b0, final_trip);
        blk = 1'b0;
        cyc(2);
        chk("unblocked final", 1'b1, final_trip);
        chk("unblocked grp2 trip", 1'b1, grp_flags[2].trip);
        set_ch(4'h8, 12'h064, 1'b0);
        cyc(1);
    endtask
    task automatic s_alarm;
        set_ch(4'h6, 12'h201, 1'b0);
        cyc(int'(alarm_delay));
        chk("alarm early", 1'b0, grp_flags[1].alarm);
        cyc(1);
        chk("alarm late", 1'b1, grp_flags[1].alarm);
        chk("any alarm", 1'b1, any_g.alarm);
        set_ch(4'h6, 12'h064, 1'b0);
        cyc(2);
        chk("alarm cleared", 1'b0, any_g.alarm);
    endtask
    task automatic s_timeout;
        set_ch(4'ha, 12'h064, 1'b1);
        cyc(1);
        chk("grp3 timeout", 1'b1, grp_flags[3].timeout);
        chk("aux timeout", 1'b1, aux_to);
        chk("wd timeout", 1'b0, wd_to);
        chk("any timeout", 1'b1, any_to);
        chk("coll timeout", 1'b1, coll_to);
        set_ch(4'ha, 12'h064, 1'b0);
        cyc(1);
        chk("coll cleared", 1'b0, coll_to);
    endtask
    task automatic s_vote;
        ch_thr[2:0] = {3{12'h100}};
        vote_cfg[0] = '{enable: 1'b1, select: 12'h007, required: 4'h2};
        tsel = 1'b1;
        set_ch(4'h0, 12'h101, 1'b0);
        cyc(1);
        chk("vote one", 1'b0, vt1);
        set_ch(4'h1, 12'h101, 1'b0);
        cyc(1);
        chk("vote two", 1'b1, vt1);
        chk("vote second", 1'b0, vt2);
        chk("vote final", 1'b1, final_trip);
        ch_enable = 12'hffd;
        cyc(2);
        chk("vote ch off", 1'b0, vt1);
        ch_enable = 12'hfff;
        func_enable = 1'b0;
        cyc(2);
        chk("vote func off", 1'b0, vt1);
        func_enable = 1'b1;
        vote_cfg[1] = '{enable: 1'b1, select: 12'h006, required: 4'h2};
        cyc(2);
        chk("vote unselected", 1'b0, vt2);
        set_ch(4'h2, 12'h101, 1'b0);
        cyc(1);
        chk("vote second trip", 1'b1, vt2);
        blk = 1'b1;
        cyc(2);
        chk("vote blocked", 1'b0, vt2);
        blk = 1'b0;
    endtask
    task automatic s_reset;
        cyc(1);
        chk("pre reset vote", 1'b1, vt1);
        nrst = 1'b0;
        cyc(1);
        chk("mid reset vote", 1'b0, vt1);
        chk("mid reset final", 1'b0, final_trip);
        nrst = 1'b1;
        cyc(2);
        chk("after reset final", 1'b0, final_trip);
    endtask

    initial begin
        #(40 * 3000);
        n_fail++;
        finish_test();
    end
    initial begin
        cyc(16);
        chk("reset final", 1'b0, final_trip);
        chk("reset coll", 1'b0, coll_to);
        nrst = 1'b1;
        cyc(2);
        s_trip_hyst();
        s_block();
        s_alarm();
        s_timeout();
        s_vote();
        s_reset();
        finish_test();
    end
endmodule
`default_nettype wire
